//--- verilog/dmm_pkg.sv
// Package: data memory map constants, operand modes and core request carriers
package dmm_pkg;

  // Region bounds
  localparam logic [7:0] RAM_LAST      = 8'h6f;
  localparam logic [7:0] ONES_FIRST    = 8'h70;
  localparam logic [7:0] ONES_LAST     = 8'h7f;
  localparam logic [7:0] REGRAM_FIRST  = 8'hf0;
  localparam logic [7:0] REGRAM_LAST   = 8'hfb;
  localparam logic [7:0] REGRAM_TOP    = 8'hff;
  localparam int         RAM_WORDS     = 112;
  localparam int         REGRAM_WORDS  = 13;
  localparam int         REG_WORDS     = 256;

  // Pointer registers
  localparam logic [7:0] ADDR_SECONDARY_POINTER = 8'hfc;
  localparam logic [7:0] ADDR_STACK_POINTER     = 8'hfd;
  localparam logic [7:0] ADDR_PRIMARY_POINTER   = 8'hfe;

  // Port pin-level and program read data registers (read only)
  localparam int         PORT_COUNT = 5;
  localparam logic [7:0] ADDR_PORTF_PIN_LEVELS = 8'h96;
  localparam logic [7:0] ADDR_PORTL_PIN_LEVELS = 8'hd2;
  localparam logic [7:0] ADDR_PORTG_PIN_LEVELS = 8'hd6;
  localparam logic [7:0] ADDR_PORTC_PIN_LEVELS = 8'hda;
  localparam logic [7:0] ADDR_PORTJ_PIN_LEVELS = 8'hde;
  localparam logic [7:0] ADDR_PROGRAM_READ_DATA = 8'haa;

  // Writable peripheral registers
  localparam int REG_COUNT = 38;
  localparam logic [REG_COUNT*8-1:0] REG_ADDRS = {
    8'h84, 8'h85, 8'h86, 8'h94, 8'h95, 8'ha8, 8'ha9, 8'hab,
    8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hc7, 8'hc8,
    8'hc9, 8'hca, 8'hcf, 8'hd0, 8'hd1, 8'hd4, 8'hd5, 8'hd8,
    8'hd9, 8'hdc, 8'hdd, 8'hdf, 8'he1, 8'he2, 8'he6, 8'he7,
    8'he8, 8'hea, 8'heb, 8'hec, 8'hed, 8'hee};
  localparam logic [7:0] ADDR_PROCESSOR_STATUS_WORD = 8'hef;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [7:0] ALL_ONES     = 8'hff;
  localparam logic [7:0] UNDEF_VALUE  = 8'h00;

  // Port output data offsets within the writable set (F, L, G, C, J)
  localparam logic [7:0] ADDR_PORTF_OUTPUT_DATA = 8'h94;
  localparam logic [7:0] ADDR_PORTL_OUTPUT_DATA = 8'hd0;
  localparam logic [7:0] ADDR_PORTG_OUTPUT_DATA = 8'hd4;
  localparam logic [7:0] ADDR_PORTC_OUTPUT_DATA = 8'hd8;
  localparam logic [7:0] ADDR_PORTJ_OUTPUT_DATA = 8'hdc;
  localparam logic [7:0] PORT_CFG_STEP          = 8'h01;

  // Operand modes
  typedef enum logic [2:0] {
    DMM_MODE_DIRECT,
    DMM_MODE_INDIRECT,
    DMM_MODE_POST_INC,
    DMM_MODE_POST_DEC,
    DMM_MODE_IMMEDIATE
  } dmm_mode_type;

  // Bit operations
  typedef enum logic [1:0] {
    DMM_BIT_NONE,
    DMM_BIT_SET,
    DMM_BIT_CLEAR,
    DMM_BIT_TEST
  } dmm_bitop_type;

  typedef struct packed {
    logic          valid;
    dmm_mode_type  mode;
    logic          use_secondary;
    logic [7:0]    operand;
    logic          write;
    logic [7:0]    wdata;
    dmm_bitop_type bitop;
    logic [2:0]    bit_sel;
    logic          short_reg;
    logic [3:0]    short_index;
  } dmm_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic       bit_value;
  } dmm_resp_type;

endpackage

//--- verilog/dmm_data_memory_map.sv
// Data memory decoder, register file and operand address generator
//
// Contract
// - RAM, ports, peripherals share one data space
// - Addresses 00-6F are 112 RAM bytes
// - Reads of 70-7F return all ones
// - Reads of 80-83, 87-93 undefined
// - F0-FB and FF are register RAM
// - Pointers at FC, SP FD, FE
// - Ports: data, configuration, read-only pin levels
// - Two-wire registers at B8 through BD
// - Program address A8/A9, read AA, write AB
// - Direct mode uses instruction address byte
// - Indirect mode uses selected pointer contents
// - Post-modify uses pointer then steps it
// - Immediate mode takes operand from instruction
// - Any bit settable, clearable, testable anywhere; set and clear only change writable storage, not pin levels, 70-7F or AA
// - Sixteen registers addressable by short forms
`timescale 1ns/1ps

module dmm_data_memory_map
  import dmm_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Core request and answer
  input  wire dmm_pkg::dmm_req_type    req,
  output dmm_pkg::dmm_resp_type        resp,
  // Port pins
  input  wire logic [7:0]              port_pins [dmm_pkg::PORT_COUNT],
  output logic      [7:0]              port_out  [dmm_pkg::PORT_COUNT],
  output logic      [7:0]              port_cfg  [dmm_pkg::PORT_COUNT],
  // Program memory read data
  input  wire logic [7:0]              program_read_data,
  output logic      [15:0]             program_address,
  // Pointers seen by the core
  output logic      [7:0]              stack_pointer_reg,
  output logic      [7:0]              primary_pointer,
  output logic      [7:0]              secondary_pointer
);
  import dmm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] ram_q     [RAM_WORDS];
  logic [7:0] regram_q  [REGRAM_WORDS];
  logic [7:0] periph_q  [REG_COUNT];
  logic [7:0] psw_q;
  logic [7:0] sec_ptr_q;
  logic [7:0] sp_q;
  logic [7:0] pri_ptr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Operand address
  logic [7:0] ptr_val;
  logic [7:0] addr_d;
  logic       is_imm;

  always_comb begin
    ptr_val = req.use_secondary ? sec_ptr_q : pri_ptr_q;
    is_imm  = (req.mode == DMM_MODE_IMMEDIATE);
    case (req.mode)
      DMM_MODE_DIRECT:    addr_d = req.operand;
      DMM_MODE_INDIRECT:  addr_d = ptr_val;
      DMM_MODE_POST_INC:  addr_d = ptr_val;
      DMM_MODE_POST_DEC:  addr_d = ptr_val;
      default:            addr_d = req.operand;
    endcase
    // Short forms reach F0-FF implicitly
    if (req.short_reg && !is_imm) begin
      addr_d = {4'hf, req.short_index};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  logic       in_ram;
  logic       in_ones;
  logic       in_regram;
  logic [3:0] regram_idx;
  logic [6:0] ram_idx;
  logic       periph_hit;
  logic [5:0] periph_idx;

  always_comb begin
    in_ram     = (addr_d <= RAM_LAST);
    in_ones    = (addr_d >= ONES_FIRST) && (addr_d <= ONES_LAST);
    in_regram  = ((addr_d >= REGRAM_FIRST) && (addr_d <= REGRAM_LAST)) ||
                 (addr_d == REGRAM_TOP);
    ram_idx    = addr_d[6:0];
    regram_idx = (addr_d == REGRAM_TOP) ? 4'hc : addr_d[3:0];
    periph_hit = 1'b0;
    periph_idx = 6'h00;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (addr_d == REG_ADDRS[(REG_COUNT-1-i)*8 +: 8]) begin
        periph_hit = 1'b1;
        periph_idx = 6'(i);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Single-register hits; the program address bytes at A8/A9 also sit in the peripheral table
  logic hit_psw;
  logic hit_sec;
  logic hit_sp;
  logic hit_pri;
  logic hit_prog_lo;
  logic hit_prog_hi;
  logic hit_prog_rd;
  logic wr_target;

  assign hit_psw     = (addr_d == ADDR_PROCESSOR_STATUS_WORD);
  assign hit_sec     = (addr_d == ADDR_SECONDARY_POINTER);
  assign hit_sp      = (addr_d == ADDR_STACK_POINTER);
  assign hit_pri     = (addr_d == ADDR_PRIMARY_POINTER);
  assign hit_prog_lo = (addr_d == REG_ADDRS[(REG_COUNT-6)*8 +: 8]);
  assign hit_prog_hi = (addr_d == REG_ADDRS[(REG_COUNT-7)*8 +: 8]);
  assign hit_prog_rd = (addr_d == ADDR_PROGRAM_READ_DATA);

  // Only real storage takes a write; reserved, pin-level, all-ones and
  // program read addresses fall through, so a stray store changes nothing
  assign wr_target = in_ram || in_regram || periph_hit || hit_psw ||
                     hit_sec || hit_sp || hit_pri;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; every map location is one byte in a single space
  logic [7:0] cur;
  logic [7:0] pins_at [PORT_COUNT];
  logic [7:0] pin_addr [PORT_COUNT];

  assign pin_addr[0] = ADDR_PORTF_PIN_LEVELS;
  assign pin_addr[1] = ADDR_PORTL_PIN_LEVELS;
  assign pin_addr[2] = ADDR_PORTG_PIN_LEVELS;
  assign pin_addr[3] = ADDR_PORTC_PIN_LEVELS;
  assign pin_addr[4] = ADDR_PORTJ_PIN_LEVELS;

  // Pin levels are live inputs; a write to these addresses has nowhere to land
  logic       pin_hit;
  logic [7:0] pin_val;

  always_comb begin
    pin_hit = 1'b0;
    pin_val = 8'h00;
    for (int p = 0; p < PORT_COUNT; p++) begin
      if (addr_d == pin_addr[p]) begin
        pin_hit = 1'b1;
        pin_val = port_pins[p];
      end
    end
  end

  always_comb begin
    cur = UNDEF_VALUE;
    if (in_ram) begin
      cur = ram_q[ram_idx];
    end else if (in_ones) begin
      cur = ALL_ONES;
    end else if (in_regram) begin
      cur = regram_q[regram_idx];
    end else if (periph_hit) begin
      cur = periph_q[periph_idx];
    end else if (addr_d == ADDR_PROCESSOR_STATUS_WORD) begin
      cur = psw_q;
    end else if (addr_d == ADDR_SECONDARY_POINTER) begin
      cur = sec_ptr_q;
    end else if (addr_d == ADDR_STACK_POINTER) begin
      cur = sp_q;
    end else if (addr_d == ADDR_PRIMARY_POINTER) begin
      cur = pri_ptr_q;
    end else if (hit_prog_rd) begin
      cur = program_read_data;
    end
    if (pin_hit) begin
      cur = pin_val;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write value: plain write or read-modify-write of one bit
  logic [7:0] wval;
  logic [7:0] bit_mask;
  logic       do_write;

  assign bit_mask = 8'h01 << req.bit_sel;

  always_comb begin
    wval = req.wdata;
    case (req.bitop)
      DMM_BIT_SET:   wval = cur | bit_mask;
      DMM_BIT_CLEAR: wval = cur & ~bit_mask;
      default:       wval = req.wdata;
    endcase
    do_write = req.valid && !is_imm && req.bitop != DMM_BIT_TEST && wr_target &&
               (req.write || req.bitop == DMM_BIT_SET || req.bitop == DMM_BIT_CLEAR);
  end

  //////////////////////////////////////////////////////////////////////////////
  // RAM stores; no reset, so the cells hold whatever they powered up with
  logic ram_we;
  logic regram_we;

  assign ram_we    = do_write && in_ram;
  assign regram_we = do_write && in_regram;

  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_q[ram_idx] <= wval;
    end
  end

  always_ff @(posedge clk) begin
    if (regram_we) begin
      regram_q[regram_idx] <= wval;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Peripheral registers, one per writable location
  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_periph
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          periph_q[g] <= REG_RESET;
        end else if (do_write && periph_hit && periph_idx == 6'(g)) begin
          periph_q[g] <= wval;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psw_q <= REG_RESET;
    end else if (do_write && hit_psw) begin
      psw_q <= wval;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pointers; an explicit write to the stepped pointer wins over the step
  logic       is_post;
  logic       step_pri;
  logic       step_sec;
  logic [7:0] step_val;

  // Short forms name a fixed register, so they never step a pointer
  assign is_post = req.valid && !req.short_reg &&
                   (req.mode == DMM_MODE_POST_INC || req.mode == DMM_MODE_POST_DEC);

  always_comb begin
    step_val = (req.mode == DMM_MODE_POST_DEC) ? ptr_val - 8'h01 : ptr_val + 8'h01;
    step_pri = is_post && !req.use_secondary;
    step_sec = is_post && req.use_secondary;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_ptr_q <= REG_RESET;
    end else if (do_write && hit_pri) begin
      pri_ptr_q <= wval;
    end else if (step_pri) begin
      pri_ptr_q <= step_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_ptr_q <= REG_RESET;
    end else if (do_write && hit_sec) begin
      sec_ptr_q <= wval;
    end else if (step_sec) begin
      sec_ptr_q <= step_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_q <= REG_RESET;
    end else if (do_write && hit_sp) begin
      sp_q <= wval;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Answer, registered one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp.valid     <= req.valid;
      resp.addr      <= is_imm ? 8'h00 : addr_d;
      resp.rdata     <= is_imm ? req.operand : cur;
      resp.bit_value <= cur[req.bit_sel];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs mirroring map state
  logic [7:0] out_addr [PORT_COUNT];

  assign out_addr[0] = ADDR_PORTF_OUTPUT_DATA;
  assign out_addr[1] = ADDR_PORTL_OUTPUT_DATA;
  assign out_addr[2] = ADDR_PORTG_OUTPUT_DATA;
  assign out_addr[3] = ADDR_PORTC_OUTPUT_DATA;
  assign out_addr[4] = ADDR_PORTJ_OUTPUT_DATA;

  generate
    for (g = 0; g < PORT_COUNT; g++) begin : g_port
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          port_out[g] <= REG_RESET;
        end else if (do_write && addr_d == out_addr[g]) begin
          port_out[g] <= wval;
        end
      end

      // Configuration sits one address above the data register
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          port_cfg[g] <= REG_RESET;
        end else if (do_write && addr_d == out_addr[g] + PORT_CFG_STEP) begin
          port_cfg[g] <= wval;
        end
      end
    end
  endgenerate

  // Program address; the table copies at A8/A9 serve the read path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      program_address <= 16'h0000;
    end else begin
      if (do_write && hit_prog_lo) begin
        program_address[7:0] <= wval;
      end
      if (do_write && hit_prog_hi) begin
        program_address[15:8] <= wval;
      end
    end
  end

  // Mirrors lag the internal pointers by one cycle: the core gets a clean
  // flop output at the cost of seeing a step one cycle late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stack_pointer_reg <= REG_RESET;
    end else begin
      stack_pointer_reg <= sp_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      primary_pointer <= REG_RESET;
    end else begin
      primary_pointer <= pri_ptr_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secondary_pointer <= REG_RESET;
    end else begin
      secondary_pointer <= sec_ptr_q;
    end
  end

endmodule // dmm_data_memory_map

//--- dv/dmm_data_memory_map_chk.sv
// Checker: operand addressing and map relations seen at the decoder ports
`timescale 1ns/1ps

module dmm_data_memory_map_chk
  import dmm_pkg::*;
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // Core side
  input wire dmm_pkg::dmm_req_type  req,
  input wire dmm_pkg::dmm_resp_type resp,
  // State outputs
  input wire logic [15:0]          program_address,
  input wire logic [7:0]           primary_pointer,
  input wire logic [7:0]           secondary_pointer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic       dir;
  logic [7:0] sel_ptr;
  assign dir = req.valid && req.mode == DMM_MODE_DIRECT && !req.short_reg;
  // Pointer outputs lag by one cycle, so only quiet-before requests are judged
  assign sel_ptr = req.use_secondary ? secondary_pointer : primary_pointer;

  AST_ANSWER_NEXT: assert property (
    resp.valid == $past(req.valid)) else $error("answer not one cycle after request");
  AST_DIRECT_ADDR: assert property (
    dir |=> resp.addr == $past(req.operand)) else $error("direct address wrong");
  AST_ONES_REGION: assert property (
    dir && req.operand[7:4] == 4'h7 |=> resp.rdata == 8'hff) else $error("upper RAM not ones");
  AST_IMMEDIATE: assert property (
    req.valid && req.mode == DMM_MODE_IMMEDIATE |=>
      resp.rdata == $past(req.operand) && resp.addr == 8'h00) else $error("immediate wrong");
  AST_INDIRECT_ADDR: assert property (
    req.valid && req.mode == DMM_MODE_INDIRECT && !req.short_reg && !$past(req.valid) |=>
      resp.addr == $past(sel_ptr)) else $error("indirect address wrong");
  AST_POST_INC: assert property (
    req.valid && req.mode == DMM_MODE_POST_INC && !req.use_secondary && !req.write
      && !req.short_reg && !$past(req.valid) |=>
      ##1 primary_pointer == $past(primary_pointer, 2) + 8'h01)
    else $error("pointer not stepped");
  AST_PROG_ADDR_LOW: assert property (
    dir && req.write && req.bitop == DMM_BIT_NONE && req.operand == 8'ha8 |=>
      program_address[7:0] == $past(req.wdata)) else $error("program address low wrong");
  AST_SHORT_FORM: assert property (
    req.valid && req.short_reg && req.mode == DMM_MODE_DIRECT |=>
      resp.addr == {4'hf, $past(req.short_index)}) else $error("short form address wrong");
  AST_BIT_TEST: assert property (
    req.valid && req.bitop == DMM_BIT_TEST && req.mode != DMM_MODE_IMMEDIATE |=>
      resp.bit_value == resp.rdata[$past(req.bit_sel)]) else $error("tested bit wrong");

  COV_POST_INC: cover property (req.valid && req.mode == DMM_MODE_POST_INC);
  COV_BIT_TEST: cover property (req.valid && req.bitop == DMM_BIT_TEST);
  COV_SHORT: cover property (req.valid && req.short_reg);
endmodule // dmm_data_memory_map_chk

//--- dv/dmm_core_model.sv
// Core model: issues one operand request and captures its answer
`timescale 1ns/1ps

module dmm_core_model
  import dmm_pkg::*;
(
  input  wire logic                  clk,
  input  wire dmm_pkg::dmm_resp_type resp,
  output dmm_pkg::dmm_req_type       req
);
  initial begin
    req = '0;
  end

  // Entered on a rising edge; leaves one idle cycle so pointer copies settle
  task automatic issue(input dmm_req_type r, output dmm_resp_type rs);
    req <= r;
    @(posedge clk);
    req.valid <= 1'b0;
    req.operand <= ~r.operand;
    @(posedge clk);
    rs = resp;
  endtask
endmodule // dmm_core_model

//--- dv/dmm_data_memory_map_tb_top.sv
// Testbench: map, pointer, immediate, bit and short-form accesses
`timescale 1ns/1ps

module dmm_data_memory_map_tb_top
  import dmm_pkg::*;
;
  logic         clk;
  logic         rst;
  dmm_req_type  req;
  dmm_resp_type resp;
  logic [7:0]   port_pins [PORT_COUNT];
  logic [7:0]   port_out [PORT_COUNT];
  logic [7:0]   port_cfg [PORT_COUNT];
  logic [7:0]   program_read_data;
  logic [15:0]  program_address;
  logic [7:0]   stack_pointer_reg;
  logic [7:0]   primary_pointer;
  logic [7:0]   secondary_pointer;
  dmm_req_type  r;
  dmm_resp_type rs;
  int           failures;
  int           check_count;
  logic [7:0]   base [PORT_COUNT] = '{8'h94, 8'hd0, 8'hd4, 8'hd8, 8'hdc};
  logic [7:0]   cells [20] = '{8'h00, 8'h6f, 8'hf0, 8'hfb, 8'hff, 8'h84, 8'h86, 8'ha8, 8'ha9,
    8'hab, 8'hb8, 8'hbd, 8'hc7, 8'hcf, 8'hdf, 8'he2, 8'he8, 8'hee, 8'hef, 8'hfd};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  dmm_data_memory_map u_dut (.clk(clk), .rst(rst), .req(req), .resp(resp),
    .port_pins(port_pins), .port_out(port_out), .port_cfg(port_cfg),
    .program_read_data(program_read_data), .program_address(program_address),
    .stack_pointer_reg(stack_pointer_reg), .primary_pointer(primary_pointer),
    .secondary_pointer(secondary_pointer));
  dmm_core_model u_core (.clk(clk), .resp(resp), .req(req));

  function automatic dmm_req_type mk(dmm_mode_type m, logic [7:0] a, logic w = 1'b0,
                                     logic [7:0] d = 8'h00);
    mk = '0;
    mk.valid = 1'b1;
    mk.mode = m;
    mk.operand = a;
    mk.write = w;
    mk.wdata = d;
  endfunction

  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic go();
    u_core.issue(r, rs);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    r = mk(DMM_MODE_DIRECT, a, 1'b1, d);
    go();
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    r = mk(DMM_MODE_DIRECT, a);
    go();
    chk("rdata", e, rs.rdata);
  endtask

  task automatic print_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #20000;
    failures++;
    $display("BAD watchdog expected done seen hang");
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    program_read_data = 8'h99;
    foreach (port_pins[i]) begin
      port_pins[i] = 8'h30 + 8'(i);
    end
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (cells[i]) begin
      wr(cells[i], cells[i] ^ 8'h5a);
      rd(cells[i], cells[i] ^ 8'h5a);
    end
    chk("prog_lo", 8'hf2, program_address[7:0]);
    chk("prog_hi", 8'hf3, program_address[15:8]);
    chk("stack", 8'ha7, stack_pointer_reg);
    // Refused writes must leave the readable map untouched
    wr(8'h7f, 8'h00);
    wr(8'h88, 8'h12);
    wr(8'haa, 8'h11);
    rd(8'h70, 8'hff);
    rd(8'h7f, 8'hff);
    rd(8'haa, 8'h99);
    for (int i = 0; i < PORT_COUNT; i++) begin
      wr(base[i], 8'ha0 + 8'(i));
      wr(base[i] + 8'h01, 8'hc0 + 8'(i));
      wr(base[i] + 8'h02, 8'h00);
      rd(base[i] + 8'h02, 8'h30 + 8'(i));
      chk("port_out", 8'ha0 + 8'(i), port_out[i]);
      chk("port_cfg", 8'hc0 + 8'(i), port_cfg[i]);
    end
    wr(ADDR_PRIMARY_POINTER, 8'h10);
    wr(ADDR_SECONDARY_POINTER, 8'h20);
    wr(8'h10, 8'h77);
    wr(8'h20, 8'h66);
    r = mk(DMM_MODE_INDIRECT, 8'h00);
    go();
    chk("ind_data", 8'h77, rs.rdata);
    r.mode = DMM_MODE_POST_INC;
    go();
    chk("inc_addr", 8'h10, rs.addr);
    r.mode = DMM_MODE_POST_DEC;
    r.use_secondary = 1'b1;
    go();
    chk("dec_data", 8'h66, rs.rdata);
    chk("inc_ptr", 8'h11, primary_pointer);
    rd(ADDR_SECONDARY_POINTER, 8'h1f);
    chk("dec_ptr", 8'h1f, secondary_pointer);
    // RAM at 6F holds 35, so an immediate that read or wrote memory shows up
    r = mk(DMM_MODE_IMMEDIATE, 8'h6f, 1'b1, 8'hee);
    go();
    chk("imm", 8'h6f, rs.rdata);
    rd(8'h6f, 8'h35);
    wr(8'h05, 8'h00);
    r = mk(DMM_MODE_DIRECT, 8'h05);
    r.bitop = DMM_BIT_SET;
    r.bit_sel = 3'd7;
    go();
    rd(8'h05, 8'h80);
    r = mk(DMM_MODE_DIRECT, 8'h94);
    r.bitop = DMM_BIT_CLEAR;
    r.bit_sel = 3'd5;
    go();
    r.bitop = DMM_BIT_TEST;
    r.bit_sel = 3'd7;
    go();
    chk("bit", 8'h80, {rs.bit_value, 7'h00});
    chk("port_bit", 8'h80, rs.rdata);
    r = mk(DMM_MODE_DIRECT, 8'h00, 1'b1, 8'h3d);
    r.short_reg = 1'b1;
    r.short_index = 4'h4;
    go();
    rd(8'hf4, 8'h3d);
    print_verdict();
  end
endmodule // dmm_data_memory_map_tb_top

bind dmm_data_memory_map dmm_data_memory_map_chk u_chk (.clk(clk), .rst(rst), .req(req),
  .resp(resp), .program_address(program_address), .primary_pointer(primary_pointer),
  .secondary_pointer(secondary_pointer));
